// File: common/pio_pkg.sv
// Constants and carrier types for the 32-line programmable I/O port.
// Assumes a 16-bit processor I/O space with word-wide register accesses.
package pio_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_LINES = 32;
    localparam int HALF      = 16;

    // ----------------------------------------------------------------
    // I/O space register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE_LO   = 16'hFF70;
    localparam logic [15:0] ADDR_DIR_LO    = 16'hFF72;
    localparam logic [15:0] ADDR_DATA_LO   = 16'hFF74;
    localparam logic [15:0] ADDR_MODE_HI   = 16'hFF76;
    localparam logic [15:0] ADDR_DIR_HI    = 16'hFF78;
    localparam logic [15:0] ADDR_DATA_HI   = 16'hFF7A;
    localparam logic [15:0] ADDR_ODRAIN_LO = 16'hFF7C;
    localparam logic [15:0] ADDR_ODRAIN_HI = 16'hFF7E;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_LO_RST = 16'h0000;
    localparam logic [15:0] DIR_LO_RST  = 16'hFC0F;  // Lines 4..9 normal
    localparam logic [15:0] MODE_HI_RST = 16'h0000;
    localparam logic [15:0] DIR_HI_RST  = 16'hFFFF;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam logic [15:0] ODRAIN_RST  = 16'h0000;
    localparam logic [15:0] ZERO16      = 16'h0000;

    // ----------------------------------------------------------------
    // Fixed per-line properties
    // ----------------------------------------------------------------
    localparam logic [31:0] PULL_UP_MASK = 32'hFFFF_FBFD;  // Lines 1, 10 pull down
    localparam logic [31:0] INVERT_MASK  = 32'hC000_3000;  // Lines 12, 13, 30, 31
    localparam logic [31:0] ZERO32       = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pio_io_req_s;

    typedef struct packed {
        logic [31:0] level;
        logic [31:0] oe;
        logic [31:0] pull_en;
        logic [31:0] pull_up;
    } pio_pin_s;

endpackage : pio_pkg

// File: hw/pio_port.sv
// Programmable I/O port: 32 lines, mode/direction per line, I/O-space registers.
// Assumes external pad logic resolves level/oe/pull into the pin wire.
`timescale 1ns/1ps

// Contract
// - Thirty-two lines, each software input or output (code: inverted lines 12, 13, 30, 31 are never software outputs)
// - Two 16-bit mode and direction register pairs
// - Mode/direction bits pick normal, pull-input, output, input
// - Pull direction fixed per line in hardware
// - Lines may be open-drain outputs
// - Reset: 4-9 normal, 1,10 pull-down, others pull-up
// - Mode code zero returns pin to peripheral
// - Status reads return low and high half levels
// - Data bit one drives high, zero low
// - Inverted interrupt lines never software outputs (peripheral may drive them in normal mode), read inverted
module pio_port
    import pio_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire pio_io_req_s io_req_in,
    output logic [15:0]      io_rdata_out,
    input  wire logic [31:0] pin_in,
    input  wire logic [31:0] periph_out_in,
    input  wire logic [31:0] periph_oe_in,
    output logic [31:0]      periph_in_out,
    output pio_pin_s         pin_drive_out
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (LINES != NUM_LINES) begin : g_bad_lines
        $error("pio_port serves exactly 32 lines");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [31:0] mode_reg,   mode_next;
    logic [31:0] dir_reg,    dir_next;
    logic [31:0] data_reg,   data_next;
    logic [31:0] odrain_reg, odrain_next;
    logic [15:0] rdata_reg,  rdata_next;
    logic [31:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
    pio_pin_s    drive_reg,  drive_next;
    logic [31:0] level;

    // ----------------------------------------------------------------
    // Pin input synchroniser and agreement filter
    // ----------------------------------------------------------------
    always_comb begin
        filt_next = filt_reg;
        for (int b = 0; b < NUM_LINES; b++) begin
            if (s2_reg[b] == s3_reg[b]) begin
                filt_next[b] = s3_reg[b];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_reg   <= ZERO32;
            s2_reg   <= ZERO32;
            s3_reg   <= ZERO32;
            filt_reg <= ZERO32;
        end else begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // Logical level seen by software
    assign level = filt_reg ^ INVERT_MASK;

    // ----------------------------------------------------------------
    // Register file: writes and status reads
    // ----------------------------------------------------------------
    always_comb begin
        mode_next   = mode_reg;
        dir_next    = dir_reg;
        data_next   = data_reg;
        odrain_next = odrain_reg;
        rdata_next  = rdata_reg;
        if (io_req_in.wr) begin
            if (io_req_in.addr == ADDR_MODE_LO) begin
                mode_next[15:0] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_DIR_LO) begin
                dir_next[15:0] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_DATA_LO) begin
                data_next[15:0] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_MODE_HI) begin
                mode_next[31:16] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_DIR_HI) begin
                dir_next[31:16] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_DATA_HI) begin
                data_next[31:16] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_ODRAIN_LO) begin
                odrain_next[15:0] = io_req_in.wdata;
            end else if (io_req_in.addr == ADDR_ODRAIN_HI) begin
                odrain_next[31:16] = io_req_in.wdata;
            end
        end
        if (io_req_in.rd) begin
            if (io_req_in.addr == ADDR_MODE_LO) begin
                rdata_next = mode_reg[15:0];
            end else if (io_req_in.addr == ADDR_DIR_LO) begin
                rdata_next = dir_reg[15:0];
            end else if (io_req_in.addr == ADDR_DATA_LO) begin
                rdata_next = level[15:0];
            end else if (io_req_in.addr == ADDR_MODE_HI) begin
                rdata_next = mode_reg[31:16];
            end else if (io_req_in.addr == ADDR_DIR_HI) begin
                rdata_next = dir_reg[31:16];
            end else if (io_req_in.addr == ADDR_DATA_HI) begin
                rdata_next = level[31:16];
            end else if (io_req_in.addr == ADDR_ODRAIN_LO) begin
                rdata_next = odrain_reg[15:0];
            end else if (io_req_in.addr == ADDR_ODRAIN_HI) begin
                rdata_next = odrain_reg[31:16];
            end else begin
                rdata_next = ZERO16;
            end
        end
    end

    // Reset state of all lines
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_reg   <= {MODE_HI_RST, MODE_LO_RST};
            dir_reg    <= {DIR_HI_RST, DIR_LO_RST};
            data_reg   <= {DATA_RST, DATA_RST};
            odrain_reg <= {ODRAIN_RST, ODRAIN_RST};
            rdata_reg  <= ZERO16;
        end else begin
            mode_reg   <= mode_next;
            dir_reg    <= dir_next;
            data_reg   <= data_next;
            odrain_reg <= odrain_next;
            rdata_reg  <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // Per-line function decode
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
        logic normal_w, output_w, pull_w;
        assign normal_w = !mode_reg[i] && !dir_reg[i];
        assign output_w = mode_reg[i] && !dir_reg[i];
        assign pull_w   = !mode_reg[i] && dir_reg[i];
        // Peripheral owns a normal line; else latch or open-drain low
        assign drive_next.level[i] = normal_w ? periph_out_in[i] :
                                     (!odrain_reg[i] && data_reg[i]);
        assign drive_next.oe[i]    = normal_w ? periph_oe_in[i] :
                                     (output_w && !INVERT_MASK[i] &&
                                      (!odrain_reg[i] || !data_reg[i]));
        assign drive_next.pull_en[i] = pull_w;
        assign drive_next.pull_up[i] = PULL_UP_MASK[i];
    end

    // Pin drive registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drive_reg <= '{level: ZERO32, oe: ZERO32,
                           pull_en: ~{DIR_HI_RST, DIR_LO_RST} ^ 32'hFFFF_FFFF,
                           pull_up: PULL_UP_MASK};
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign pin_drive_out = drive_reg;
    assign io_rdata_out  = rdata_reg;
    assign periph_in_out = filt_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    AST_NORMAL_PASS: assert property (
        (!mode_reg[4] && !dir_reg[4]) |=> pin_drive_out.oe[4] == $past(periph_oe_in[4]))
        else $error("normal line not handed to peripheral");
    AST_OUT_DRIVE: assert property (
        (mode_reg[0] && !dir_reg[0] && !odrain_reg[0])
        |=> pin_drive_out.oe[0] && pin_drive_out.level[0] == $past(data_reg[0]))
        else $error("output line not driving latch value");
    AST_INV_NO_OUT: assert property (
        (mode_reg[31] || dir_reg[31]) |=> !pin_drive_out.oe[31])
        else $error("inverted line driven as output");
    AST_PULL_EN: assert property (
        pin_drive_out.pull_en[2] == $past(!mode_reg[2] && dir_reg[2]))
        else $error("pull enable wrong for mode");
    AST_PULL_FIXED: assert property (
        pin_drive_out.pull_up == PULL_UP_MASK)
        else $error("pull direction changed");
    AST_ODRAIN: assert property (
        (mode_reg[0] && !dir_reg[0] && odrain_reg[0] && data_reg[0])
        |=> !pin_drive_out.oe[0])
        else $error("open-drain line drove high");
    AST_READ_HI: assert property (
        (io_req_in.rd && io_req_in.addr == ADDR_DATA_HI)
        |=> io_rdata_out == $past(filt_reg[31:16] ^ INVERT_MASK[31:16]))
        else $error("high status read wrong");
    AST_DIR_WRITE: assert property (
        (io_req_in.wr && io_req_in.addr == ADDR_DIR_HI)
        |=> dir_reg[31:16] == $past(io_req_in.wdata) ##1 pin_drive_out.pull_en[31:16]
            == $past(~mode_reg[31:16] & dir_reg[31:16]))
        else $error("direction write lost");
    AST_LATCH_HOLD: assert property (
        !(io_req_in.wr && (io_req_in.addr == ADDR_DATA_LO || io_req_in.addr == ADDR_DATA_HI))
        |=> $stable(data_reg))
        else $error("data latch changed without write");
    AST_FILTER: assert property (
        $changed(filt_reg[0]) |-> $past(s2_reg[0] == s3_reg[0]))
        else $error("input changed without agreement");

    COV_OUTPUT:  cover property (mode_reg[0] && !dir_reg[0] ##1 pin_drive_out.oe[0]);
    COV_ODRAIN:  cover property (odrain_reg[0] && mode_reg[0] && !dir_reg[0]);
    COV_READ_LO: cover property (io_req_in.rd && io_req_in.addr == ADDR_DATA_LO);
    COV_NORMAL:  cover property (!mode_reg[1] && !dir_reg[1] ##1 pin_drive_out.oe[1]);

endmodule : pio_port

// File: dv/pio_board_model.sv
// Board side of the port: pads, weak pulls and external drivers.
// Assumes the port's drive carrier and a bench-controlled external source.
`timescale 1ns/1ps
module pio_board_model
    import pio_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire pio_pin_s    pin_drive_in,
    input  wire logic [31:0] ext_en_in,
    input  wire logic [31:0] ext_val_in,
    output logic [31:0]      pin_out
);
    logic [31:0] float_reg = 32'h5555_5555;
    logic [31:0] ext_ok;

    // Released lines without pull toggle every clock, so the port's filter holds their last agreed level
    always @(posedge sys_clk_in) float_reg <= ~float_reg;

    // Board never pulls lines 26 and 29 low while reset is held
    assign ext_ok = ext_en_in &
                    ~((arst_n_in ? 32'h0000_0000 : 32'h2400_0000) & ~ext_val_in);

    // Pad resolution: own drive, then board, then weak pull, else floating
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_drive_in.oe[i]) pin_out[i] = pin_drive_in.level[i];
            else if (ext_ok[i]) pin_out[i] = ext_val_in[i];
            else if (pin_drive_in.pull_en[i]) pin_out[i] = pin_drive_in.pull_up[i];
            else pin_out[i] = float_reg[i];
        end
    end
endmodule : pio_board_model

// File: dv/tb.sv
// Self-checking bench for the programmable I/O port.
// Assumes word register accesses and the board model on the pin side.
`timescale 1ns/1ps
module tb
    import pio_pkg::*;
;
    localparam logic [3:0] OE_TAB   = 4'b0101;
    localparam logic [3:0] PULL_TAB = 4'b0010;
    logic        sys_clk_in = 1'b0;
    logic        arst_n_in  = 1'b0;
    pio_io_req_s req        = '0;
    logic [15:0] rdata;
    logic [31:0] pin, p_in, p_out = '0, p_oe = '1, ext_en = '0, ext_val = '0;
    pio_pin_s    drv;
    int          failures = 0;
    int          checks_done = 0;

    // ----------------------------------------------------------------
    // Clock, design and board
    // ----------------------------------------------------------------
    always #10 sys_clk_in = ~sys_clk_in;

    pio_port pio_port_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .io_req_in(req),
        .io_rdata_out(rdata), .pin_in(pin), .periph_out_in(p_out), .periph_oe_in(p_oe),
        .periph_in_out(p_in), .pin_drive_out(drv));
    pio_board_model pio_board_model_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .pin_drive_in(drv), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin));

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask : io_wr

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("Error %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("Error %0t: lines %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge sys_clk_in);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        #1 chk16(rdata, exp, m);
    endtask : rd_chk

    task automatic test_done;
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        settle(3);
        chk32(drv.pull_en, 32'hFFFF_FC0F, '1);
        chk32(drv.oe, 32'h0000_0000, '1);
        repeat (3) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        settle(8);
        rd_chk(ADDR_MODE_LO, 16'h0000, '1);
        rd_chk(ADDR_DIR_LO, 16'hFC0F, '1);
        rd_chk(ADDR_DIR_HI, 16'hFFFF, '1);
        rd_chk(16'hFF00, 16'h0000, '1);
        rd_chk(ADDR_DATA_LO, 16'hC80D, '1);
        rd_chk(ADDR_DATA_HI, 16'h3FFF, '1);
        ext_en <= 32'h0000_2000;
        settle(6);
        rd_chk(ADDR_DATA_LO, 16'h2000, 16'h3000);
        chk32(p_in, 32'h0000_0000, 32'h0000_2000);
        ext_en <= '0;
        io_wr(ADDR_DATA_LO, 16'h0004);
        for (int m = 0; m < 4; m++) begin
            io_wr(ADDR_MODE_LO, m[1] ? 16'h0004 : 16'h0000);
            io_wr(ADDR_DIR_LO, m[0] ? 16'hFC0F : 16'hFC0B);
            settle(1);
            chk32(drv.oe, {32{OE_TAB[m]}}, 32'h0000_0004);
            chk32(drv.pull_en, {32{PULL_TAB[m]}}, 32'h0000_0004);
            chk32(drv.level, {32{m == 2}}, {29'h0, OE_TAB[m], 2'h0});
        end
        io_wr(ADDR_DIR_LO, 16'hFC0B);
        settle(6);
        rd_chk(ADDR_DATA_LO, 16'h0004, 16'h0004);
        io_wr(ADDR_MODE_LO, 16'h0000);
        io_wr(ADDR_MODE_LO, 16'h0004);
        settle(1);
        chk32(drv.level, '1, 32'h0000_0004);
        io_wr(ADDR_ODRAIN_LO, 16'h0004);
        settle(1);
        chk32(drv.oe, 32'h0000_0000, 32'h0000_0004);
        io_wr(ADDR_DATA_LO, 16'h0000);
        settle(1);
        chk32(drv.oe & ~drv.level, '1, 32'h0000_0004);
        io_wr(ADDR_MODE_LO, 16'h1000);
        io_wr(ADDR_DIR_LO, 16'hEC0D);
        p_out <= 32'h0000_0002;
        settle(1);
        chk32(drv.oe, 32'h0000_0002, 32'h0000_1002);
        chk32(drv.level, 32'h0000_0002, 32'h0000_0002);
        // Peripheral releases line one; the pad must follow its enable
        p_oe <= 32'hFFFF_FFFD;
        settle(1);
        chk32(drv.oe, 32'h0000_0000, 32'h0000_0002);
        io_wr(ADDR_DIR_HI, 16'hE73C);
        io_wr(ADDR_MODE_HI, 16'h0000);
        io_wr(ADDR_MODE_HI, 16'h0001);
        io_wr(ADDR_DATA_HI, 16'h0001);
        settle(1);
        chk32(drv.oe & drv.level, 32'h0001_0000, 32'h0001_0000);
        rd_chk(ADDR_DIR_HI, 16'hE73C, '1);
        chk32(drv.pull_up, 32'hFFFF_FBFD, '1);
        test_done();
    end
endmodule : tb
